// >>> hw/ppiat_top.sv
// pwm output stage: brake, polarity, interrupt flags and adc trigger
// How it works
// (RL1) system fail brake picks one condition
// (RL2) separate polarity invert for channel 0, 1
// (RL3) zero flag set at counter zero
// (RL4) period flag set at period point
// (RL5) stored 16-bit compare value, match every cycle
// (RL6) match while counting up sets compare-up flag
// (RL7) match while counting down sets compare-down flag
// (RL8) flags reach interrupt only when enabled
// (RL9) one interrupt output per pwm pair
// (RL10) brake raises configured edge/level brake flags
// (RL11) four-bit select picks adc trigger event
// (RL12) adc trigger only while trigger enabled
// (RL13) five trigger events, other codes unused
// (RL14) both detectors watch the same five sources
// (RL15) comparator sources only on rising edge
// (RL16) flags stay until written one to clear
// (RL17) adc trigger is a one-clock pulse
// (RL18) polarity applied after dead-time insertion
`timescale 1ns/100ps
module ppiat_top (
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  input  wire ppiat_pkg::ppiat_cnt_t         cnt,
  input  wire logic [1:0]                    dt_wave,
  input  wire logic [15:0]                   compare_value,
  input  wire logic                          compare_load,
  input  wire logic [1:0]                    polarity_ctl,
  input  wire logic [7:0]                    adc_trigger_ctl,
  input  wire logic [7:0]                    flag_irq_enable,
  input  wire logic [7:0]                    flag_clear,
  input  wire ppiat_pkg::ppiat_brk_in_t      brake_in,
  input  wire ppiat_pkg::ppiat_sysfail_sel_t sysfail_sel,
  input  wire logic [4:0]                    brake_edge_src_en,
  input  wire logic [4:0]                    brake_level_src_en,
  input  wire logic [1:0]                    brake_edge_ch_en,
  input  wire logic [1:0]                    brake_level_ch_en,
  output logic                               pwm_out_a,
  output logic                               pwm_out_b,
  output logic                               pwm_irq,
  output logic                               adc_trigger,
  output logic [7:0]                         flag_status,
  output logic [1:0]                         brake_active,
  output logic [15:0]                        compare_value_q
);

  // all state of the stage
  typedef struct packed {
    logic [15:0] cmp;
    logic [1:0]  edge_sts;
    logic [1:0]  level_sts;
    logic [1:0]  brk;
    logic        out_a;
    logic        out_b;
    logic        irq;
    logic        trig;
    logic [7:0]  sts;
  } ppiat_top_st_t;

  ppiat_top_st_t st_r;
  ppiat_top_st_t st_nxt;

  logic [4:0] edge_hit;
  logic [4:0] level_hit;
  logic [7:0] flags;
  logic [7:0] flag_set;
  logic       match;
  logic       match_up;
  logic       match_dn;
  logic       edge_brk;
  logic       level_brk;
  logic       ch0_polarity_invert;
  logic       ch1_polarity_invert;
  logic [3:0] adc_trigger_select;
  logic       adc_trigger_enable;
  logic       trig_evt;
  logic [7:0] flags_nxt;
  logic [1:0] braked;
  logic       wave_a;
  logic       wave_b;

  // brake source conditioning
  ppiat_brake_src u_brake_src (
    .clk_sys     (clk_sys),
    .nrst        (nrst),
    .src_in      (brake_in),
    .sysfail_sel (sysfail_sel),
    .edge_hit    (edge_hit),
    .level_hit   (level_hit)
  );

  // sticky status flags
  ppiat_sticky u_flags (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .set     (flag_set),
    .clr     (flag_clear),
    .flags   (flags)
  );

  // control field split
  assign ch0_polarity_invert = polarity_ctl[ppiat_pkg::POL_CH0];
  assign ch1_polarity_invert = polarity_ctl[ppiat_pkg::POL_CH1];
  assign adc_trigger_select  = adc_trigger_ctl[ppiat_pkg::TRG_SEL_MSB:ppiat_pkg::TRG_SEL_LSB];
  assign adc_trigger_enable  = adc_trigger_ctl[ppiat_pkg::TRG_EN_BIT];

  // compare match against the stored value, split by direction
  always_comb begin
    match    = (cnt.value == st_r.cmp); // [RL5]
    match_up = match & cnt.dir_up;      // [RL6]
    match_dn = match & ~cnt.dir_up;     // [RL7]
  end

  // brake events gated by the chosen sources [RL14]
  always_comb begin
    edge_brk  = |(edge_hit & brake_edge_src_en);
    level_brk = |(level_hit & brake_level_src_en);
  end

  // hardware set terms for every flag
  always_comb begin
    flag_set                         = 8'h00;
    flag_set[ppiat_pkg::FLAG_ZERO]   = cnt.zero;   // [RL3]
    flag_set[ppiat_pkg::FLAG_PERIOD] = cnt.period; // [RL4]
    flag_set[ppiat_pkg::FLAG_CMP_UP] = match_up;   // [RL6]
    flag_set[ppiat_pkg::FLAG_CMP_DN] = match_dn;   // [RL7]
    flag_set[ppiat_pkg::FLAG_BRK_E0] = edge_brk & brake_edge_ch_en[0];   // [RL10]
    flag_set[ppiat_pkg::FLAG_BRK_E1] = edge_brk & brake_edge_ch_en[1];   // [RL10]
    flag_set[ppiat_pkg::FLAG_BRK_L0] = level_brk & brake_level_ch_en[0]; // [RL10]
    flag_set[ppiat_pkg::FLAG_BRK_L1] = level_brk & brake_level_ch_en[1]; // [RL10]
  end

  // flag value the bank will hold next, for a registered irq and status
  always_comb begin
    flags_nxt = flag_set | (flags & ~flag_clear); // [RL16]
  end

  // adc trigger event select, unused codes give nothing [RL11] [RL13]
  always_comb begin
    unique case (adc_trigger_select)
      ppiat_pkg::TRG_ZERO:        trig_evt = cnt.zero;
      ppiat_pkg::TRG_PERIOD:      trig_evt = cnt.period;
      ppiat_pkg::TRG_ZERO_PERIOD: trig_evt = cnt.zero | cnt.period;
      ppiat_pkg::TRG_CMP_UP:      trig_evt = match_up;
      ppiat_pkg::TRG_CMP_DN:      trig_evt = match_dn;
      default:                    trig_evt = 1'b0;
    endcase
  end

  // a channel is held in brake while either status bit stands
  always_comb begin
    braked = st_r.edge_sts | st_r.level_sts;
    wave_a = dt_wave[0] & ~braked[0];
    wave_b = dt_wave[1] & ~braked[1];
  end

  // next state of the whole stage
  always_comb begin
    st_nxt = st_r;
    // compare value holds until a load
    if (compare_load) begin
      st_nxt.cmp = compare_value; // [RL5]
    end
    // edge brake status: stays until flag cleared and a new period starts
    for (int c = 0; c < 2; c++) begin
      if (flag_set[ppiat_pkg::FLAG_BRK_E0 + c]) begin
        st_nxt.edge_sts[c] = 1'b1;
      end else if (cnt.zero && !flags[ppiat_pkg::FLAG_BRK_E0 + c]) begin
        st_nxt.edge_sts[c] = 1'b0;
      end
      // level brake status: released at period start once condition gone
      if (flag_set[ppiat_pkg::FLAG_BRK_L0 + c]) begin
        st_nxt.level_sts[c] = 1'b1;
      end else if (cnt.zero && !level_brk) begin
        st_nxt.level_sts[c] = 1'b0;
      end
    end
    // registered copy of the per-channel brake state for the output port
    st_nxt.brk   = st_nxt.edge_sts | st_nxt.level_sts;
    // polarity after dead time and brake, complement when inverted
    st_nxt.out_a = wave_a ^ ch0_polarity_invert; // [RL2] [RL18]
    st_nxt.out_b = wave_b ^ ch1_polarity_invert; // [RL2] [RL18]
    // one interrupt for this pair, enabled flags only
    st_nxt.irq   = |(flags_nxt & flag_irq_enable); // [RL8] [RL9]
    // single-cycle trigger, only when enabled
    st_nxt.trig  = trig_evt & adc_trigger_enable; // [RL12] [RL17]
    st_nxt.sts   = flags_nxt;
  end

  // stage registers
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{cmp: ppiat_pkg::CMP_RST, sts: ppiat_pkg::FLAG_RST, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign pwm_out_a       = st_r.out_a;
  assign pwm_out_b       = st_r.out_b;
  assign pwm_irq         = st_r.irq;
  assign adc_trigger     = st_r.trig;
  assign flag_status     = st_r.sts;
  assign brake_active    = st_r.brk;
  assign compare_value_q = st_r.cmp;

endmodule

// >>> hw/ppiat_pkg.sv
// shared constants and carrier types for the pwm output and event stage
package ppiat_pkg;

  // flag vector layout, interrupt status bits first
  localparam int FLAG_W        = 8;
  localparam int FLAG_ZERO     = 0;
  localparam int FLAG_PERIOD   = 1;
  localparam int FLAG_CMP_UP   = 2;
  localparam int FLAG_CMP_DN   = 3;
  localparam int FLAG_BRK_E0   = 4;
  localparam int FLAG_BRK_E1   = 5;
  localparam int FLAG_BRK_L0   = 6;
  localparam int FLAG_BRK_L1   = 7;

  // polarity control bit positions
  localparam int POL_CH0       = 0;
  localparam int POL_CH1       = 1;

  // brake source vector layout
  localparam int BRK_SRC_W     = 5;
  localparam int BRK_PIN       = 0;
  localparam int BRK_CMP0      = 1;
  localparam int BRK_CMP1      = 2;
  localparam int BRK_SYSFAIL   = 3;
  localparam int BRK_SOFT      = 4;

  // adc trigger field layout
  localparam int TRG_SEL_MSB   = 3;
  localparam int TRG_SEL_LSB   = 0;
  localparam int TRG_EN_BIT    = 7;
  localparam int CMP_W         = 16;

  // reset values
  localparam logic [15:0] CMP_RST   = 16'h0000;
  localparam logic [7:0]  FLAG_RST  = 8'h00;

  // system fail condition select
  typedef enum logic [1:0] {
    PPIAT_SF_CLOCK,
    PPIAT_SF_BROWNOUT,
    PPIAT_SF_LOCKUP,
    PPIAT_SF_NONE
  } ppiat_sysfail_sel_t;

  // adc trigger sources, other codes unused
  localparam logic [3:0] TRG_ZERO        = 4'h0;
  localparam logic [3:0] TRG_PERIOD      = 4'h1;
  localparam logic [3:0] TRG_ZERO_PERIOD = 4'h2;
  localparam logic [3:0] TRG_CMP_UP      = 4'h3;
  localparam logic [3:0] TRG_CMP_DN      = 4'h4;

  // counter state from the pulse generator
  typedef struct packed {
    logic        zero;
    logic        period;
    logic        dir_up;
    logic [15:0] value;
  } ppiat_cnt_t;

  // raw brake and fail inputs
  typedef struct packed {
    logic brake_pin;
    logic comparator0_out;
    logic comparator1_out;
    logic clock_fail;
    logic brownout_detect;
    logic cpu_lockup;
    logic soft_brake;
  } ppiat_brk_in_t;

endpackage

// >>> hw/ppiat_brake_src.sv
// brake source conditioning: system fail select and edge/level hits
`timescale 1ns/100ps
module ppiat_brake_src (
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  input  wire ppiat_pkg::ppiat_brk_in_t src_in,
  input  wire ppiat_pkg::ppiat_sysfail_sel_t sysfail_sel,
  output logic [4:0]                    edge_hit,
  output logic [4:0]                    level_hit
);

  typedef struct packed {
    logic [4:0] prev;
  } ppiat_bsrc_st_t;

  ppiat_bsrc_st_t st_r;
  ppiat_bsrc_st_t st_nxt;
  logic           sys_fail;
  logic [4:0]     now;
  logic [4:0]     rise;

  // pick the one system fail condition that feeds the brake [RL1]
  always_comb begin
    unique case (sysfail_sel)
      ppiat_pkg::PPIAT_SF_CLOCK:    sys_fail = src_in.clock_fail;
      ppiat_pkg::PPIAT_SF_BROWNOUT: sys_fail = src_in.brownout_detect;
      ppiat_pkg::PPIAT_SF_LOCKUP:   sys_fail = src_in.cpu_lockup;
      ppiat_pkg::PPIAT_SF_NONE:     sys_fail = 1'b0;
    endcase
  end

  // five sources, same set for both detectors [RL14]
  always_comb begin
    now                         = 5'h00;
    now[ppiat_pkg::BRK_PIN]     = src_in.brake_pin;
    now[ppiat_pkg::BRK_CMP0]    = src_in.comparator0_out;
    now[ppiat_pkg::BRK_CMP1]    = src_in.comparator1_out;
    now[ppiat_pkg::BRK_SYSFAIL] = sys_fail;
    now[ppiat_pkg::BRK_SOFT]    = src_in.soft_brake;
    st_nxt.prev                 = now;
    rise                        = now & ~st_r.prev;
  end

  // comparators count only on a rising edge, even for the level path [RL15]
  always_comb begin
    edge_hit                       = rise;
    level_hit                      = now;
    level_hit[ppiat_pkg::BRK_CMP0] = rise[ppiat_pkg::BRK_CMP0];
    level_hit[ppiat_pkg::BRK_CMP1] = rise[ppiat_pkg::BRK_CMP1];
  end

  // previous source levels
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// >>> hw/ppiat_sticky.sv
// sticky flag bank, hardware set beats write-one clear
`timescale 1ns/100ps
module ppiat_sticky (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic [7:0] set,
  input  wire logic [7:0] clr,
  output logic [7:0]      flags
);

  typedef struct packed {
    logic [7:0] flags;
  } ppiat_stk_st_t;

  ppiat_stk_st_t st_r;
  ppiat_stk_st_t st_nxt;

  // per-bit hold, set wins over clear [RL16]
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < ppiat_pkg::FLAG_W; i++) begin
      st_nxt.flags[i] = set[i] | (st_r.flags[i] & ~clr[i]);
    end
  end

  assign flags = st_r.flags;

  // flag storage
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{flags: ppiat_pkg::FLAG_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// >>> bench/ppiat_properties.sv
// checker for the pwm output and event stage
`timescale 1ns/100ps
module ppiat_checker (
  input wire logic                  clk_sys,
  input wire logic                  nrst,
  input wire ppiat_pkg::ppiat_cnt_t cnt,
  input wire logic [1:0]            dt_wave,
  input wire logic                  compare_load,
  input wire logic [1:0]            polarity_ctl,
  input wire logic [7:0]            adc_trigger_ctl,
  input wire logic [7:0]            flag_irq_enable,
  input wire logic [7:0]            flag_clear,
  input wire logic                  pwm_out_a,
  input wire logic                  pwm_irq,
  input wire logic                  adc_trigger,
  input wire logic [7:0]            flag_status,
  input wire logic [1:0]            brake_active,
  input wire logic [15:0]           compare_value_q
);
  logic live_r;
  logic hit;
  logic mt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // marks cycles after the first edge out of reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) live_r <= 1'b0;
    else live_r <= 1'b1;
  end
  // expected trigger event for the current select
  always_comb begin
    mt = cnt.value == compare_value_q;
    case (adc_trigger_ctl[3:0])
      ppiat_pkg::TRG_ZERO:        hit = cnt.zero;
      ppiat_pkg::TRG_PERIOD:      hit = cnt.period;
      ppiat_pkg::TRG_ZERO_PERIOD: hit = cnt.zero | cnt.period;
      ppiat_pkg::TRG_CMP_UP:      hit = mt & cnt.dir_up;
      ppiat_pkg::TRG_CMP_DN:      hit = mt & !cnt.dir_up;
      default:                    hit = 1'b0;
    endcase
    hit = hit & adc_trigger_ctl[7];
  end
  a_pol_out: assert property (live_r && brake_active == 2'b00
    && $past(brake_active) == 2'b00 |-> pwm_out_a == ($past(dt_wave[0]) ^ $past(polarity_ctl[0])))
    else $error("pwm_out_a polarity wrong");
  a_zero_set: assert property (cnt.zero |=> flag_status[0])
    else $error("zero flag not set");
  a_period_set: assert property (cnt.period |=> flag_status[1])
    else $error("period flag not set");
  a_cmp_up: assert property (mt && cnt.dir_up && !compare_load |=> flag_status[2])
    else $error("compare up flag not set");
  a_cmp_dn: assert property (mt && !cnt.dir_up && !compare_load |=> flag_status[3])
    else $error("compare down flag not set");
  a_flag_keep: assert property (live_r |->
    ($past(flag_status) & ~$past(flag_clear) & ~flag_status) == 8'h00)
    else $error("flag dropped without clear");
  a_irq_mask: assert property (live_r |-> pwm_irq == |(flag_status & $past(flag_irq_enable)))
    else $error("irq does not match enabled flags");
  a_trig_pulse: assert property (live_r |-> adc_trigger == $past(hit))
    else $error("adc trigger wrong");
endmodule
bind ppiat_top ppiat_checker i_ppiat_checker (.clk_sys, .nrst, .cnt, .dt_wave, .compare_load,
  .polarity_ctl, .adc_trigger_ctl, .flag_irq_enable, .flag_clear, .pwm_out_a, .pwm_irq,
  .adc_trigger, .flag_status, .brake_active, .compare_value_q);

// >>> bench/ppiat_adc_sink.sv
// adc side model counting conversion starts
`timescale 1ns/100ps
module ppiat_adc_sink (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       adc_trigger,
  output logic [7:0]      trig_cnt
);
  // one conversion start per trigger cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) trig_cnt <= 8'h00;
    else if (adc_trigger) trig_cnt <= trig_cnt + 8'h01;
  end
endmodule

// >>> bench/pwm_polarity_irq_adc_trigger_tb.sv
// testbench for the pwm output and event stage
`timescale 1ns/100ps
module pwm_polarity_irq_adc_trigger_tb;
  localparam ppiat_pkg::ppiat_cnt_t IDLE = '{1'b0, 1'b0, 1'b1, 16'h0001};
  logic clk_sys, nrst, compare_load, pwm_out_a, pwm_out_b, pwm_irq, adc_trigger, ex;
  ppiat_pkg::ppiat_cnt_t cnt;
  ppiat_pkg::ppiat_brk_in_t brake_in;
  ppiat_pkg::ppiat_sysfail_sel_t sysfail_sel;
  logic [1:0] dt_wave, polarity_ctl, brake_edge_ch_en, brake_level_ch_en, brake_active;
  logic [4:0] brake_edge_src_en, brake_level_src_en;
  logic [7:0] adc_trigger_ctl, flag_irq_enable, flag_clear, flag_status, trig_cnt;
  logic [15:0] compare_value, compare_value_q;
  int error_cnt, total_checks, exp_trig;
  ppiat_top i_ppiat_top (.clk_sys, .nrst, .cnt, .dt_wave, .compare_value, .compare_load,
    .polarity_ctl, .adc_trigger_ctl, .flag_irq_enable, .flag_clear, .brake_in, .sysfail_sel,
    .brake_edge_src_en, .brake_level_src_en, .brake_edge_ch_en, .brake_level_ch_en,
    .pwm_out_a, .pwm_out_b, .pwm_irq, .adc_trigger, .flag_status, .brake_active,
    .compare_value_q);
  ppiat_adc_sink i_ppiat_adc_sink (.clk_sys, .nrst, .adc_trigger, .trig_cnt);
  // 100 ns clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task complete_run;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one counter event cycle, outputs settled on return
  task automatic ev(input logic z, input logic p, input logic d, input logic [15:0] v);
    @(posedge clk_sys);
    cnt <= '{z, p, d, v};
    @(posedge clk_sys);
    cnt <= IDLE;
    #1;
  endtask
  task clr;
    @(posedge clk_sys);
    flag_clear <= 8'hFF;
    @(posedge clk_sys);
    flag_clear <= 8'h00;
    #1;
  endtask
  // bounded wait on brake and flag state
  task automatic wait_st(input logic [9:0] m, input logic [9:0] v);
    int i = 0;
    while (({brake_active, flag_status} & m) !== v) begin
      @(posedge clk_sys);
      #1;
      i++;
      if (i > 20) begin
        error_cnt++;
        $display("MISMATCH wait expected %h seen %h", v, {brake_active, flag_status} & m);
        complete_run();
      end
    end
  endtask
  initial begin
    nrst = 1'b0; cnt = IDLE; dt_wave = 2'b00; compare_value = 16'h0000; compare_load = 1'b0;
    polarity_ctl = 2'b00; adc_trigger_ctl = 8'h00; flag_irq_enable = 8'h00;
    flag_clear = 8'h00; brake_in = '0; sysfail_sel = ppiat_pkg::PPIAT_SF_NONE;
    brake_edge_src_en = 5'h00; brake_level_src_en = 5'h00;
    brake_edge_ch_en = 2'b00; brake_level_ch_en = 2'b00;
    error_cnt = 0; total_checks = 0; exp_trig = 0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    compare_value <= 16'h1234;
    compare_load <= 1'b1;
    @(posedge clk_sys);
    compare_load <= 1'b0;
    #1;
    chk("cmp_q", 16'h1234, compare_value_q);
    clr();
    // every waveform and polarity pairing
    for (int k = 0; k < 16; k++) begin
      @(posedge clk_sys);
      dt_wave <= k[1:0];
      polarity_ctl <= k[3:2];
      @(posedge clk_sys);
      #1;
      chk("pwm_out", {14'h0, k[1:0] ^ k[3:2]}, {14'h0, pwm_out_b, pwm_out_a});
    end
    // all select codes, enabled then disabled, four events each
    for (int s = 0; s < 32; s++) begin
      for (int e = 0; e < 4; e++) begin
        @(posedge clk_sys);
        adc_trigger_ctl <= {~s[4], 3'h0, s[3:0]};
        flag_irq_enable <= {4'h0, {4{~s[4]}}};
        ev(e == 0, e == 1, e == 2, e < 2 ? 16'h0001 : 16'h1234);
        ex = !s[4] && (s[3:0] == (e < 2 ? e : e + 1) || (s[3:0] == 2 && e < 2));
        exp_trig += int'(ex);
        chk("trig", {15'h0, ex}, {15'h0, adc_trigger});
        chk("flags", 16'(1 << e), {8'h0, flag_status});
        chk("irq", {15'h0, ~s[4]}, {15'h0, pwm_irq});
        clr();
        chk("trig_end", 16'h0, {15'h0, adc_trigger});
        chk("cleared", 16'h0, {7'h0, pwm_irq, flag_status});
      end
    end
    chk("adc_starts", 16'(exp_trig), {8'h0, trig_cnt});
    // software edge brake on both channels
    @(posedge clk_sys);
    polarity_ctl <= 2'b01;
    dt_wave <= 2'b00;
    brake_edge_src_en <= 5'h10;
    brake_edge_ch_en <= 2'b11;
    @(posedge clk_sys);
    brake_in.soft_brake <= 1'b1;
    wait_st(10'h330, 10'h330);
    @(posedge clk_sys);
    #1;
    chk("brk_out", 16'h1, {14'h0, pwm_out_b, pwm_out_a});
    @(posedge clk_sys);
    brake_in.soft_brake <= 1'b0;
    clr();
    ev(1'b1, 1'b0, 1'b0, 16'h0001);
    wait_st(10'h300, 10'h000);
    clr();
    // level brake from system fail, wrong then right condition
    @(posedge clk_sys);
    sysfail_sel <= ppiat_pkg::PPIAT_SF_CLOCK;
    brake_level_src_en <= 5'h08;
    brake_level_ch_en <= 2'b01;
    brake_in.brownout_detect <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk("sf_other", 16'h0, {8'h0, flag_status});
    @(posedge clk_sys);
    sysfail_sel <= ppiat_pkg::PPIAT_SF_BROWNOUT;
    wait_st(10'h0C0, 10'h040);
    // comparator on the level path: one hit per rising edge only
    @(posedge clk_sys);
    sysfail_sel <= ppiat_pkg::PPIAT_SF_LOCKUP;
    brake_level_src_en <= 5'h0A;
    brake_level_ch_en <= 2'b10;
    brake_in.comparator0_out <= 1'b1;
    wait_st(10'h080, 10'h080);
    clr();
    repeat (3) @(posedge clk_sys);
    #1;
    chk("cmp_level", 16'h0, {8'h0, flag_status});
    // level brake released at period start with comparator0 still high, as no new hit arrives
    ev(1'b1, 1'b0, 1'b0, 16'h0001);
    wait_st(10'h300, 10'h000);
    complete_run();
  end
endmodule
